// >>> rtl/smsq_consts.svh
`ifndef SMSQ_CONSTS_SVH
`define SMSQ_CONSTS_SVH

// Register offsets on the management register port.
`define SMSQ_OFS_GAIN      16'h0467
`define SMSQ_OFS_MANUAL    16'h0468
`define SMSQ_OFS_RUN       16'h046A
`define SMSQ_OFS_READOUT   16'h047B

// Reset values.
`define SMSQ_RST_GAIN      16'h0012
`define SMSQ_RST_MANUAL    16'h0920
`define SMSQ_RST_RUN       16'h0094
`define SMSQ_RST_READOUT   16'h0000

// Field positions of the run control register.
`define SMSQ_RUN_START     0
`define SMSQ_RUN_PERIODIC  1
`define SMSQ_RUN_HOLD      2
`define SMSQ_RUN_FORCE     3
`define SMSQ_RUN_DIV_LO    4
`define SMSQ_RUN_DIV_HI    5
`define SMSQ_RUN_AVG       6
`define SMSQ_RUN_DISCARD   7
`define SMSQ_RUN_HISTCLR   8
`define SMSQ_RUN_RW_MASK   16'h01FE

// Field positions of the manual and decimation register.
`define SMSQ_MAN_SEL_LO    0
`define SMSQ_MAN_SEL_HI    2
`define SMSQ_MAN_RDSEL_LO  12
`define SMSQ_MAN_RDSEL_HI  14
`define SMSQ_MAN_HOLD      15

// Sample counts for discard and averaging.
`define SMSQ_CNT_SHORT     3'h2
`define SMSQ_CNT_LONG      3'h4

// Converter clock timing.
`define SMSQ_SYS_CLK_KHZ   100000
`define SMSQ_ADC_FAST_KHZ  12500
`define SMSQ_ADC_DIV_FAST  (`SMSQ_SYS_CLK_KHZ / `SMSQ_ADC_FAST_KHZ)

`endif

// >>> rtl/smsq_pkg.sv
package smsq_pkg;

  // Register word of the management port.
  typedef logic [15:0] smsq_word_t;

  // Sequencer states, one-hot.
  typedef enum logic [4:0] {
    SMSQ_IDLE    = 5'b00001,
    SMSQ_LINK    = 5'b00010,
    SMSQ_DISCARD = 5'b00100,
    SMSQ_AVG     = 5'b01000,
    SMSQ_STORE   = 5'b10000
  } smsq_state_e;

endpackage

// >>> rtl/smsq_clk_div.sv
`timescale 1ns/1ps
`include "smsq_consts.svh"

module smsq_clk_div #(
  parameter int CNT_W = 5
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic [1:0] divSel,
  output logic            adcClk,
  output logic            sampleTick
);

  logic [CNT_W-1:0] cnt;             // Divider count within one period.
  logic [CNT_W-1:0] next_cnt;        // Next divider count.
  logic             next_adcClk;     // Next converter clock level.
  logic             next_tick;       // Next sample strobe.
  logic [CNT_W-1:0] lastCnt;         // Final count of the active period.
  logic [1:0]       shift;           // Doublings of the fastest period.
  logic [1:0]       activeSel;       // Divider setting used this period.
  logic [1:0]       next_activeSel;  // Setting for the next period.
  logic             wrap;            // The active period ends this cycle.

  // A new setting is only taken up where a period ends, so a change of
  // rate never leaves a shortened high or low phase on the converter clock.
  // The reserved setting falls back to the slowest rate, so the converter
  // is never clocked faster than software might expect.
  always_comb
  begin
    shift = (activeSel == 2'h3) ? 2'h2 : activeSel;
    lastCnt = CNT_W'((`SMSQ_ADC_DIV_FAST << shift) - 1);
    wrap = (cnt == lastCnt);
    next_cnt = wrap ? '0 : (cnt + CNT_W'(1));
    next_activeSel = wrap ? divSel : activeSel;
    next_tick = !wrap && (next_cnt == lastCnt);
    next_adcClk = (next_cnt > (lastCnt >> 1));
  end

  // Registered so that the clock pin and strobe are glitch free.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      cnt <= '0;
      activeSel <= 2'h0;
      adcClk <= 1'b0;
      sampleTick <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      activeSel <= next_activeSel;
      adcClk <= next_adcClk;
      sampleTick <= next_tick;
    end
  end

endmodule // smsq_clk_div

// >>> rtl/smsq_top.sv
`timescale 1ns/1ps
`include "smsq_consts.svh"

module smsq_top #(
  parameter int NUM_SENSORS = 8,
  parameter int DATA_W      = 16
) (
  input  wire logic               sys_clk,
  input  wire logic               rst_b,
  input  wire logic [15:0]        regAddr,
  input  wire logic               regWr,
  input  wire logic               regRd,
  input  smsq_pkg::smsq_word_t    regWrData,
  output smsq_pkg::smsq_word_t    regRdData,
  input  wire logic               linkUp,
  input  wire logic               manualOverride,
  input  wire logic [DATA_W-1:0]  adcData,
  output logic                    adcClk,
  output logic [2:0]              sensorSel,
  output logic                    sensorHold,
  output logic                    monitorBusy,
  output smsq_pkg::smsq_word_t    analogGainCtrl,
  output logic [8:0]              decimationCtrl
);
  import smsq_pkg::*;

  smsq_word_t        gainReg;            // Analog gain control word.
  smsq_word_t        manReg;             // Manual and decimation word.
  smsq_word_t        runReg;             // Run control word.
  smsq_word_t        readout;            // Readout value register.
  smsq_state_e       state;              // Sequencer state.
  logic [2:0]        fsmSel;             // Sensor chosen by the sequencer.
  logic [2:0]        sampleCnt;          // Samples seen in this phase.
  logic [DATA_W+1:0] accum;              // Running sum for the average.
  logic [DATA_W-1:0] hist [NUM_SENSORS]; // Averaged result per sensor.
  logic              sampleTick;         // One-cycle converter sample strobe.

  smsq_word_t        next_gainReg;
  smsq_word_t        next_manReg;
  smsq_word_t        next_runReg;
  smsq_word_t        next_readout;
  smsq_word_t        next_regRdData;
  smsq_state_e       next_state;
  logic [2:0]        next_fsmSel;
  logic [2:0]        next_sampleCnt;
  logic [DATA_W+1:0] next_accum;
  logic [DATA_W-1:0] next_hist [NUM_SENSORS];

  logic              holdNow;            // Hold control, including a write.
  logic              startNow;           // Start request this cycle.
  logic [2:0]        discardTarget;      // Samples to throw away.
  logic [2:0]        avgTarget;          // Samples to average.
  logic [DATA_W+1:0] avgValue;           // Sum scaled to one sample.
  logic              lastSensor;         // Sequencer on its final sensor.

  smsq_clk_div #(
    .CNT_W      (5)
  ) u_clk_div (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .divSel     (runReg[`SMSQ_RUN_DIV_HI:`SMSQ_RUN_DIV_LO]),
    .adcClk     (adcClk),
    .sampleTick (sampleTick)
  );

  // Register file: writes, self-clearing start and registered read data.
  always_comb
  begin
    next_gainReg = gainReg;
    next_manReg = manReg;
    next_runReg = runReg;
    next_regRdData = regRdData;
    next_runReg[`SMSQ_RUN_START] = 1'b0;
    if (regWr && (regAddr == `SMSQ_OFS_GAIN))
    begin
      next_gainReg = regWrData;
    end
    else if (regWr && (regAddr == `SMSQ_OFS_MANUAL))
    begin
      next_manReg = regWrData;
    end
    else if (regWr && (regAddr == `SMSQ_OFS_RUN))
    begin
      // Reserved bits stay zero; start lives for a single cycle only.
      next_runReg = (regWrData & `SMSQ_RUN_RW_MASK) |
                    {15'h0000, regWrData[`SMSQ_RUN_START]};
    end
    if (regRd)
    begin
      // Unmapped offsets read as zero.
      if (regAddr == `SMSQ_OFS_GAIN)
        next_regRdData = gainReg;
      else if (regAddr == `SMSQ_OFS_MANUAL)
        next_regRdData = manReg;
      else if (regAddr == `SMSQ_OFS_RUN)
        next_regRdData = runReg;
      else if (regAddr == `SMSQ_OFS_READOUT)
        next_regRdData = readout;
      else
        next_regRdData = 16'h0000;
    end
  end

  // Register file storage.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      gainReg <= `SMSQ_RST_GAIN;
      manReg <= `SMSQ_RST_MANUAL;
      runReg <= `SMSQ_RST_RUN;
      regRdData <= 16'h0000;
    end
    else
    begin
      gainReg <= next_gainReg;
      manReg <= next_manReg;
      runReg <= next_runReg;
      regRdData <= next_regRdData;
    end
  end

  // Sequencer: next state, counters, averaging and history.
  always_comb
  begin
    holdNow = runReg[`SMSQ_RUN_HOLD] ||
              (regWr && (regAddr == `SMSQ_OFS_RUN) &&
               regWrData[`SMSQ_RUN_HOLD]);
    startNow = runReg[`SMSQ_RUN_START];
    discardTarget = runReg[`SMSQ_RUN_DISCARD] ? `SMSQ_CNT_LONG
                                              : `SMSQ_CNT_SHORT;
    avgTarget = runReg[`SMSQ_RUN_AVG] ? `SMSQ_CNT_LONG : `SMSQ_CNT_SHORT;
    avgValue = runReg[`SMSQ_RUN_AVG] ? (accum >> 2) : (accum >> 1);
    lastSensor = (fsmSel == 3'(NUM_SENSORS - 1));
    next_state = state;
    next_fsmSel = fsmSel;
    next_sampleCnt = sampleCnt;
    next_accum = accum;
    for (int i = 0; i < NUM_SENSORS; i++)
      next_hist[i] = hist[i];
    case (state)
      SMSQ_IDLE:
      begin
        next_fsmSel = 3'h0;
        next_sampleCnt = 3'h0;
        next_accum = '0;
        if (startNow)
          next_state = SMSQ_LINK;
      end
      SMSQ_LINK:
      begin
        if (runReg[`SMSQ_RUN_FORCE] || linkUp)
          next_state = SMSQ_DISCARD;
      end
      SMSQ_DISCARD:
      begin
        if (sampleTick)
        begin
          if (sampleCnt == discardTarget - 3'h1)
          begin
            next_sampleCnt = 3'h0;
            next_accum = '0;
            next_state = SMSQ_AVG;
          end
          else
            next_sampleCnt = sampleCnt + 3'h1;
        end
      end
      SMSQ_AVG:
      begin
        if (sampleTick)
        begin
          next_accum = accum + {2'b00, adcData};
          if (sampleCnt == avgTarget - 3'h1)
            next_state = SMSQ_STORE;
          else
            next_sampleCnt = sampleCnt + 3'h1;
        end
      end
      SMSQ_STORE:
      begin
        if (!runReg[`SMSQ_RUN_HISTCLR])
          next_hist[fsmSel] = avgValue[DATA_W-1:0];
        next_sampleCnt = 3'h0;
        next_accum = '0;
        next_state = SMSQ_DISCARD;
        if (lastSensor)
        begin
          next_fsmSel = 3'h0;
          next_state = runReg[`SMSQ_RUN_PERIODIC] ? SMSQ_LINK : SMSQ_IDLE;
        end
        else
          next_fsmSel = fsmSel + 3'h1;
      end
      default:
      begin
        next_state = SMSQ_IDLE;
      end
    endcase
    if (runReg[`SMSQ_RUN_HISTCLR])
    begin
      for (int i = 0; i < NUM_SENSORS; i++)
        next_hist[i] = '0;
    end
    if (holdNow)
    begin
      next_state = SMSQ_IDLE;
      next_fsmSel = 3'h0;
      next_sampleCnt = 3'h0;
      next_accum = '0;
    end
    next_readout = 16'(hist[manReg[`SMSQ_MAN_RDSEL_HI:`SMSQ_MAN_RDSEL_LO]]);
  end

  // Sequencer storage; the history is a plain array in this module.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      state <= SMSQ_IDLE;
      fsmSel <= 3'h0;
      sampleCnt <= 3'h0;
      accum <= '0;
      readout <= `SMSQ_RST_READOUT;
      for (int i = 0; i < NUM_SENSORS; i++)
        hist[i] <= '0;
    end
    else
    begin
      state <= next_state;
      fsmSel <= next_fsmSel;
      sampleCnt <= next_sampleCnt;
      accum <= next_accum;
      readout <= next_readout;
      for (int i = 0; i < NUM_SENSORS; i++)
        hist[i] <= next_hist[i];
    end
  end

  // Sensor drive; the override takes select and hold from the manual word, but the sequencer and monitorBusy keep running.
  always_comb
  begin
    if (manualOverride)
    begin
      sensorHold = manReg[`SMSQ_MAN_HOLD];
      sensorSel = manReg[`SMSQ_MAN_SEL_HI:`SMSQ_MAN_SEL_LO];
    end
    else
    begin
      sensorHold = (state == SMSQ_IDLE) || (state == SMSQ_LINK);
      sensorSel = fsmSel;
    end
    monitorBusy = (state != SMSQ_IDLE);
    analogGainCtrl = gainReg;
    decimationCtrl = manReg[11:3];
  end

endmodule // smsq_top

// >>> verif/smsq_sensor_model.sv
`timescale 1ns/1ps
// Sensor bank and converter: each sensor reads a fixed code unless held.
module smsq_sensor_model (
  input  wire logic       sys_clk,
  input  wire logic [2:0] sensorSel,
  input  wire logic       sensorHold,
  output logic     [15:0] adcData = 16'h0000
);
  // A sensor held in reset has no valid level, so it toggles.
  always_ff @(posedge sys_clk)
  begin
    if (sensorHold)
      adcData <= ~adcData;
    else
      adcData <= {13'h0800, sensorSel};
  end
endmodule // smsq_sensor_model

// >>> verif/smsq_top_sva.sv
`timescale 1ns/1ps
// Port checker; helpers flag writes to the run and manual words.
module smsq_top_sva (
  input wire logic            sys_clk,
  input wire logic            rst_b,
  input wire logic [15:0]     regAddr,
  input wire logic            regWr,
  input wire logic            regRd,
  input smsq_pkg::smsq_word_t regWrData,
  input smsq_pkg::smsq_word_t regRdData,
  input wire logic            manualOverride,
  input wire logic            adcClk,
  input wire logic [2:0]      sensorSel,
  input wire logic            sensorHold,
  input wire logic            monitorBusy,
  input smsq_pkg::smsq_word_t analogGainCtrl,
  input wire logic [8:0]      decimationCtrl
);
  import smsq_pkg::*;
  logic wrRun; // Write to the run word.
  logic wrMan; // Write to the manual word.
  assign wrRun = regWr && regAddr == 16'h046A;
  assign wrMan = regWr && regAddr == 16'h0468;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  AST_HOLD_ABORT: assert property (wrRun && regWrData[2] |=> !monitorBusy)
    else $error("hold did not stop the sequencer");
  AST_START_LAUNCH: assert property ($rose(monitorBusy) |->
    $past(wrRun && regWrData[0], 2)) else $error("busy without start");
  AST_ADC_HALF: assert property ($rose(adcClk) |=> adcClk [*3])
    else $error("converter clock too fast");
  AST_MAN_SEL: assert property (wrMan && manualOverride ##1 manualOverride
    |-> sensorSel == $past(regWrData[2:0])) else $error("manual select");
  AST_MAN_HOLD: assert property (wrMan && manualOverride ##1 manualOverride
    |-> sensorHold == $past(regWrData[15])) else $error("manual hold");
  AST_UNMAPPED: assert property (regRd && regAddr == 16'h0000 |=>
    regRdData == 16'h0000) else $error("unmapped read not zero");
  AST_RUN_RSVD: assert property (regRd && regAddr == 16'h046A |=>
    regRdData[15:9] == 7'h00) else $error("run word reserved bits");
  AST_GAIN_COPY: assert property (regWr && regAddr == 16'h0467 |=>
    analogGainCtrl == $past(regWrData)) else $error("gain copy");
  AST_DEC_COPY: assert property (wrMan |=>
    decimationCtrl == $past(regWrData[11:3])) else $error("decimation copy");
endmodule // smsq_top_sva
bind smsq_top smsq_top_sva sva_i (.sys_clk, .rst_b, .regAddr, .regWr, .regRd,
  .regWrData, .regRdData, .manualOverride, .adcClk, .sensorSel, .sensorHold,
  .monitorBusy, .analogGainCtrl, .decimationCtrl);

// >>> verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import smsq_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [15:0] regAddr = 16'h0000;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  smsq_word_t  regWrData = 16'h0000;
  smsq_word_t  regRdData;
  logic        linkUp = 1'b0;
  logic        manualOverride = 1'b0;
  logic [15:0] adcData;
  logic        adcClk;
  logic [2:0]  sensorSel;
  logic        sensorHold;
  logic        monitorBusy;
  smsq_word_t  analogGainCtrl;
  logic [8:0]  decimationCtrl;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          cyc = 0;

  always #5 sys_clk = ~sys_clk;

  smsq_top dut (.sys_clk, .rst_b, .regAddr, .regWr, .regRd, .regWrData,
    .regRdData, .linkUp, .manualOverride, .adcData, .adcClk, .sensorSel,
    .sensorHold, .monitorBusy, .analogGainCtrl, .decimationCtrl);
  smsq_sensor_model partner (.sys_clk, .sensorSel, .sensorHold, .adcData);

  // A hang is cut short well after the longest expected run.
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_fail++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input smsq_word_t got, input smsq_word_t exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask

  // Strobes are one-cycle pulses, launched on the falling edge.
  task automatic wr(input smsq_word_t a, input smsq_word_t d);
    @(negedge sys_clk);
    regAddr = a;
    regWrData = d;
    regWr = 1'b1;
    @(negedge sys_clk);
    regWr = 1'b0;
  endtask

  // Read data is registered, so it is taken one edge after the strobe.
  task automatic rchk(input smsq_word_t a, input smsq_word_t exp);
    @(negedge sys_clk);
    regAddr = a;
    regRd = 1'b1;
    @(negedge sys_clk);
    regRd = 1'b0;
    chk(regRdData, exp);
  endtask

  // The state moves one edge after the start write lands.
  task automatic busyLen(output int n);
    n = 0;
    @(negedge sys_clk);
    while (monitorBusy === 1'b1 && n < 5000) @(negedge sys_clk) n++;
  endtask

  task automatic adcPeriod(output int p);
    p = 0;
    while (adcClk !== 1'b0) @(negedge sys_clk);
    while (adcClk !== 1'b1) @(negedge sys_clk);
    while (adcClk !== 1'b0) @(negedge sys_clk) p++;
    while (adcClk !== 1'b1) @(negedge sys_clk) p++;
  endtask

  task automatic t_reset();
    rchk(16'h0467, 16'h0012);
    rchk(16'h0468, 16'h0920);
    rchk(16'h046A, 16'h0094);
    rchk(16'h047B, 16'h0000);
    rchk(16'h0000, 16'h0000);
    chk(16'(decimationCtrl), 16'h0124);
    wr(16'h047B, 16'hFFFF);
    rchk(16'h047B, 16'h0000);
    wr(16'h0467, 16'hA5C3);
    rchk(16'h0467, 16'hA5C3);
    chk(analogGainCtrl, 16'hA5C3);
    wr(16'h046A, 16'h0095);
    repeat (3) @(negedge sys_clk);
    chk(16'(monitorBusy), 16'h0000);
    rchk(16'h046A, 16'h0094);
    $display("test reset done");
  endtask

  task automatic t_abort();
    wr(16'h046A, 16'h000B);
    @(negedge sys_clk);
    chk(16'(monitorBusy), 16'h0001);
    rchk(16'h046A, 16'h000A);
    repeat (600) @(negedge sys_clk);
    chk(16'(monitorBusy), 16'h0001);
    wr(16'h046A, 16'h000E);
    chk(16'(monitorBusy), 16'h0000);
    $display("test abort done");
  endtask

  task automatic t_link();
    int n;
    wr(16'h0468, 16'h3920);
    wr(16'h046A, 16'h0001);
    repeat (400) @(negedge sys_clk);
    chk(16'(monitorBusy), 16'h0001);
    linkUp = 1'b1;
    busyLen(n);
    chk(16'(n < 400), 16'h0001);
    repeat (3) @(negedge sys_clk);
    rchk(16'h047B, 16'h4003);
    wr(16'h0468, 16'h7920);
    rchk(16'h047B, 16'h4007);
    wr(16'h046A, 16'h0109);
    busyLen(n);
    rchk(16'h047B, 16'h0000);
    wr(16'h046A, 16'h0009);
    busyLen(n);
    repeat (3) @(negedge sys_clk);
    rchk(16'h047B, 16'h4007);
    linkUp = 1'b0;
    $display("test link done");
  endtask

  task automatic t_timing();
    smsq_word_t cfg [6] = '{16'h0009, 16'h0089, 16'h00C9, 16'h0019,
                            16'h0029, 16'h0039};
    int per [6] = '{8, 8, 8, 16, 32, 32};
    int ns [6] = '{4, 6, 8, 4, 4, 4};
    int n;
    int p;
    int e;
    for (int i = 0; i < 6; i++)
    begin
      wr(16'h046A, cfg[i]);
      busyLen(n);
      e = 8 * ns[i] * per[i];
      chk(16'(n >= e - per[i] && n <= e + per[i] + 12), 16'h0001);
      rchk(16'h047B, 16'h4007);
      adcPeriod(p);
      chk(16'(p), 16'(per[i]));
    end
    $display("test timing done");
  endtask

  task automatic t_manual();
    manualOverride = 1'b1;
    wr(16'h0468, 16'h8925);
    chk(16'(sensorSel), 16'h0005);
    chk(16'(sensorHold), 16'h0001);
    wr(16'h0468, 16'h0922);
    chk(16'(sensorSel), 16'h0002);
    chk(16'(sensorHold), 16'h0000);
    manualOverride = 1'b0;
    $display("test manual done");
  endtask

  initial
  begin
    repeat (20) @(negedge sys_clk);
    rst_b = 1'b1;
    t_reset();
    t_abort();
    t_link();
    t_timing();
    t_manual();
    conclude();
  end
endmodule // testbench
